// *** hdl/dcf_pkg.sv ***
package dcf_pkg;

	// ==========================================================
	// Sizes
	localparam int WORD_W = 36;
	localparam int PTR_W = 11;
	localparam int OFS_W = 10;
	localparam logic [PTR_W-1:0] DEPTH_COUNT = 11'h400;
	localparam logic [35:0] WORD_ZERO = 36'h0_0000_0000;

	// ==========================================================
	// Offset programming and start-up counts
	localparam logic [OFS_W-1:0] PRESET_LO = 10'h008;
	localparam logic [OFS_W-1:0] PRESET_MID = 10'h010;
	localparam logic [OFS_W-1:0] PRESET_HI = 10'h040;
	localparam logic [4:0] SER_BITS = 5'h14;
	localparam logic [1:0] PAR_WRITES = 2'h2;
	localparam logic [1:0] LIVE_DELAY = 2'h2;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		OFS_PRESET,
		OFS_PARALLEL,
		OFS_SERIAL
	} dcf_method_t;

	typedef struct packed {
		logic fall_through;
		logic big_endian;
		logic bus_match;
		logic byte_size;
		dcf_method_t method;
		logic [OFS_W-1:0] ofs_full;
		logic [OFS_W-1:0] ofs_empty;
	} dcf_cfg_t;

	typedef struct packed {
		logic enable;
		logic direction;
		logic mailbox_select;
		logic [WORD_W-1:0] data;
	} dcf_port_req_t;

endpackage

// *** hdl/dcf_fifo.sv ***
`timescale 1ns/1ns
//Overview of operation
//[RULE_01] A port acts on a clock edge only while its enable is high.
//[RULE_02] Write-side flag shows full in standard mode, space available in fall-through mode.
//[RULE_03] At master reset offset selects and serial select choose preset, parallel or serial.
//[RULE_04] Serial loading shifts one data bit per edge while serial enable is low.
//[RULE_05] The loader supplies twenty serial bits for this depth.
//[RULE_06] Serial stream fills almost-full offset first from its MSB, last bit ends almost-empty.
//[RULE_07] Low serial select at master reset picks serial loading, high picks parallel or preset.
//[RULE_08] Port A write with mailbox select high fills first mailbox, else the queue.
//[RULE_09] Port A read with mailbox select high returns the second mailbox.
//[RULE_10] Port B read returns first mailbox when selected, else queue output register.
//[RULE_11] Port B writes only reach the second mailbox, never the queue.
//[RULE_12] First mailbox flag drops on its write, blocks writes, rises on port B mailbox read.
//[RULE_13] Second mailbox flag drops on its write, blocks writes, rises on port A mailbox read.
//[RULE_14] Master or partial reset drives both mailbox flags high.
//[RULE_15] Master reset clears pointers and output, latches method, bus size and byte order.
//[RULE_16] Secondary master reset clears the second mailbox.
//[RULE_17] Partial reset clears pointers and output but keeps all configuration; the code reloads fall-through from the endian/timing pin after it.
//[RULE_18] Retransmit strobe rewinds the read pointer, standard mode only.
//[RULE_19] Bus match high: size select high gives bytes, low gives words; held static.
//[RULE_20] Port A direction high writes, low reads; data output released while high.
//[RULE_21] Port B direction low writes, high reads; data output released while low.
//[RULE_22] After master reset the endian/timing pin picks standard (high) or fall-through (low).
//[RULE_23] Endian/timing high during master reset sends most significant part first.
//[RULE_24] Bus match low gives full 36-bit port B with no splitting.
//[RULE_25] Read-side flag is data valid in fall-through mode, not-empty in standard mode.
//[RULE_26] Pointer comparisons that make flags are safe across the two port timings.
//[RULE_27] Narrow port B delivers each entry as successive parts in the latched order.
module dcf_fifo
	import dcf_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_arst_n,
	// Port requests
	input wire dcf_port_req_t i_port_a,
	input wire dcf_port_req_t i_port_b,
	// Reset and mode pins
	input wire logic i_primary_master_reset_n,
	input wire logic i_secondary_master_reset_n,
	input wire logic i_partial_reset_n,
	input wire logic i_retransmit_strobe_n,
	input wire logic i_endian_or_timing_select,
	input wire logic i_bus_match_select,
	input wire logic i_size_select,
	input wire logic i_serial_program_select,
	input wire logic i_offset_select_hi_serial_enable,
	input wire logic i_offset_select_lo_serial_data,
	// Port data outputs
	output logic [WORD_W-1:0] o_port_a_data,
	output logic o_port_a_data_oe,
	output logic [WORD_W-1:0] o_port_b_data,
	output logic o_port_b_data_oe,
	// Flags
	output logic o_full_or_input_ready_flag,
	output logic o_empty_or_output_ready_flag,
	output logic o_almost_empty_flag_n,
	output logic o_almost_full_flag_n,
	output logic o_first_mailbox_flag,
	output logic o_second_mailbox_flag
);

	// ==========================================================
	// Reset and strobe pin filters
	logic [3:0] pin_raw;
	logic [3:0] pin_lvl;
	assign pin_raw = {i_retransmit_strobe_n, i_partial_reset_n, i_secondary_master_reset_n, i_primary_master_reset_n};

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_pin
			logic [2:0] stage;
			logic lvl;
			always_ff @(posedge i_clock or negedge i_arst_n) begin
				if (!i_arst_n) begin
					stage <= 3'h7;
					lvl <= 1'b1;
				end else begin
					stage <= {stage[1:0], pin_raw[g]};
					lvl <= (stage[1] == stage[2]) ? stage[2] : lvl;
				end
			end
			assign pin_lvl[g] = lvl;
		end
	endgenerate

	logic mrs_act, secondary_master_reset_act, prs_act, mrs_rise, rt_evt, mrs_prev, rt_prev;
	assign mrs_act = !pin_lvl[0];
	assign secondary_master_reset_act = !pin_lvl[1];
	assign prs_act = !pin_lvl[2];
	assign mrs_rise = pin_lvl[0] && !mrs_prev;
	assign rt_evt = !pin_lvl[3] && rt_prev;

	// ==========================================================
	// State
	logic [WORD_W-1:0] mem [0:1023];
	dcf_cfg_t cfg, next_cfg;
	logic live, next_live;
	logic [1:0] live_cnt, next_live_cnt, prog_left, next_prog_left, lane, next_lane;
	logic [4:0] ser_cnt, next_ser_cnt;
	logic [PTR_W-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
	logic [WORD_W-1:0] hold, next_hold, out_a, next_out_a, out_b, next_out_b;
	logic [WORD_W-1:0] mbx1, next_mbx1, mbx2, next_mbx2;
	logic hold_valid, next_hold_valid, flag1, next_flag1, flag2, next_flag2, mem_we;

	logic [PTR_W-1:0] count;
	logic q_empty, q_full, a_wr, a_rd, b_wr, b_rd, b_qrd;
	logic [1:0] last_lane;
	logic [WORD_W-1:0] head;

	// Single clock: both pointers live in one domain, so plain comparison is safe
	assign count = wr_ptr - rd_ptr; // RULE_26
	assign q_empty = (wr_ptr == rd_ptr);
	assign q_full = (count == DEPTH_COUNT);
	assign a_wr = i_port_a.enable && i_port_a.direction; // RULE_01 RULE_20
	assign a_rd = i_port_a.enable && !i_port_a.direction;
	assign b_wr = i_port_b.enable && !i_port_b.direction; // RULE_01 RULE_21
	assign b_rd = i_port_b.enable && i_port_b.direction;
	assign b_qrd = b_rd && !i_port_b.mailbox_select;
	assign head = mem[rd_ptr[PTR_W-2:0]];
	assign last_lane = !cfg.bus_match ? 2'h0 : (cfg.byte_size ? 2'h3 : 2'h1); // RULE_24 RULE_19

	// Picks the part of an entry that leaves port B at a given lane
	function automatic logic [WORD_W-1:0] piece(input logic [WORD_W-1:0] w, input logic [1:0] ln,
		input dcf_cfg_t c);
		int idx;
		logic [WORD_W-1:0] r;
		idx = 0;
		r = w;
		if (c.bus_match && c.byte_size) begin
			idx = c.big_endian ? 3 - int'(ln) : int'(ln); // RULE_23
			r = {27'h000_0000, w[idx*9 +: 9]};
		end else if (c.bus_match) begin
			idx = c.big_endian ? 1 - int'(ln[0]) : int'(ln[0]);
			r = {18'h0_0000, w[idx*18 +: 18]};
		end
		return r;
	endfunction

	// ==========================================================
	// Next-state logic
	always_comb begin
		next_cfg = cfg;
		next_live = live;
		next_live_cnt = live_cnt;
		next_prog_left = prog_left;
		next_ser_cnt = ser_cnt;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_hold = hold;
		next_hold_valid = hold_valid;
		next_lane = lane;
		next_out_a = out_a;
		next_out_b = out_b;
		next_mbx1 = mbx1;
		next_mbx2 = mbx2;
		next_flag1 = flag1;
		next_flag2 = flag2;
		mem_we = 1'b0;
		if (mrs_act || prs_act) begin
			next_wr_ptr = '0; // RULE_15 RULE_17
			next_rd_ptr = '0;
			next_out_b = WORD_ZERO;
			next_hold_valid = 1'b0;
			next_lane = 2'h0;
			next_live = 1'b0;
			next_live_cnt = 2'h0;
			next_flag1 = 1'b1; // RULE_14
			next_flag2 = 1'b1;
		end else begin
			if (mrs_rise) begin
				next_cfg.big_endian = i_endian_or_timing_select; // RULE_15 RULE_23
				next_cfg.bus_match = i_bus_match_select;
				next_cfg.byte_size = i_size_select;
				next_ser_cnt = 5'h00;
				next_prog_left = 2'h0;
				if (!i_serial_program_select) begin
					next_cfg.method = OFS_SERIAL; // RULE_07
				end else if (!i_offset_select_hi_serial_enable && !i_offset_select_lo_serial_data) begin
					next_cfg.method = OFS_PARALLEL; // RULE_03
					next_prog_left = PAR_WRITES;
				end else begin
					next_cfg.method = OFS_PRESET;
					next_cfg.ofs_full = i_offset_select_hi_serial_enable ?
						(i_offset_select_lo_serial_data ? PRESET_HI : PRESET_MID) : PRESET_LO;
					next_cfg.ofs_empty = next_cfg.ofs_full;
				end
			end
			if (!live) begin
				next_live_cnt = live_cnt + 2'h1;
				if (live_cnt == LIVE_DELAY - 2'h1) begin
					next_live = 1'b1;
					next_cfg.fall_through = !i_endian_or_timing_select; // RULE_22
				end
			end
			if (cfg.method == OFS_SERIAL && ser_cnt != SER_BITS && !i_offset_select_hi_serial_enable) begin
				{next_cfg.ofs_full, next_cfg.ofs_empty} = {cfg.ofs_full[OFS_W-2:0], cfg.ofs_empty,
					i_offset_select_lo_serial_data}; // RULE_04 RULE_06
				next_ser_cnt = ser_cnt + 5'h01;
			end
			// Mailbox reads first so a same-cycle mailbox write wins the flag
			if (a_rd && i_port_a.mailbox_select) begin
				next_out_a = mbx2; // RULE_09
				next_flag2 = 1'b1; // RULE_13
			end
			if (b_rd && i_port_b.mailbox_select) begin
				next_out_b = mbx1; // RULE_10
				next_flag1 = 1'b1; // RULE_12
			end
			if (a_wr && i_port_a.mailbox_select && flag1) begin
				next_mbx1 = i_port_a.data; // RULE_08
				next_flag1 = 1'b0; // RULE_12
			end else if (a_wr && !i_port_a.mailbox_select && live) begin
				if (prog_left == PAR_WRITES) begin
					next_cfg.ofs_full = i_port_a.data[OFS_W-1:0];
					next_prog_left = prog_left - 2'h1;
				end else if (prog_left != 2'h0) begin
					next_cfg.ofs_empty = i_port_a.data[OFS_W-1:0];
					next_prog_left = prog_left - 2'h1;
				end else if (!q_full) begin
					mem_we = 1'b1; // RULE_08
					next_wr_ptr = wr_ptr + 11'h001;
				end
			end
			if (b_wr && i_port_b.mailbox_select && flag2) begin
				next_mbx2 = i_port_b.data; // RULE_11
				next_flag2 = 1'b0; // RULE_13
			end
			if (!cfg.fall_through) begin
				if (b_qrd && lane != 2'h0) begin
					next_out_b = piece(hold, lane, cfg); // RULE_27 RULE_10
					next_lane = (lane == last_lane) ? 2'h0 : lane + 2'h1;
				end else if (b_qrd && !q_empty) begin
					next_hold = head;
					next_out_b = piece(head, 2'h0, cfg);
					next_rd_ptr = rd_ptr + 11'h001;
					next_lane = (last_lane == 2'h0) ? 2'h0 : 2'h1;
				end
				if (rt_evt) begin
					next_rd_ptr = '0; // RULE_18
					next_lane = 2'h0;
				end
			end else if (live && !(b_rd && i_port_b.mailbox_select)) begin
				if (b_qrd && hold_valid && lane != last_lane) begin
					next_out_b = piece(hold, lane + 2'h1, cfg); // RULE_27
					next_lane = lane + 2'h1;
				end else if (!hold_valid || (b_qrd && lane == last_lane)) begin
					next_lane = 2'h0;
					if (!q_empty) begin
						next_hold = head; // RULE_25
						next_hold_valid = 1'b1;
						next_out_b = piece(head, 2'h0, cfg);
						next_rd_ptr = rd_ptr + 11'h001;
					end else begin
						next_hold_valid = 1'b0;
					end
				end
			end
		end
		if (mrs_act || secondary_master_reset_act) begin
			next_flag2 = 1'b1; // RULE_14
			if (secondary_master_reset_act) begin
				next_mbx2 = WORD_ZERO; // RULE_16
			end
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cfg <= dcf_cfg_t'('0);
			live <= 1'b0;
			live_cnt <= 2'h0;
			prog_left <= 2'h0;
			ser_cnt <= 5'h00;
			wr_ptr <= '0;
			rd_ptr <= '0;
			hold <= WORD_ZERO;
			hold_valid <= 1'b0;
			lane <= 2'h0;
			out_a <= WORD_ZERO;
			out_b <= WORD_ZERO;
			mbx1 <= WORD_ZERO;
			mbx2 <= WORD_ZERO;
			flag1 <= 1'b1;
			flag2 <= 1'b1;
			mrs_prev <= 1'b1;
			rt_prev <= 1'b1;
		end else begin
			cfg <= next_cfg;
			live <= next_live;
			live_cnt <= next_live_cnt;
			prog_left <= next_prog_left;
			ser_cnt <= next_ser_cnt;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			hold <= next_hold;
			hold_valid <= next_hold_valid;
			lane <= next_lane;
			out_a <= next_out_a;
			out_b <= next_out_b;
			mbx1 <= next_mbx1;
			mbx2 <= next_mbx2;
			flag1 <= next_flag1;
			flag2 <= next_flag2;
			mrs_prev <= pin_lvl[0];
			rt_prev <= pin_lvl[3];
		end
	end

	always_ff @(posedge i_clock) begin
		if (mem_we) begin
			mem[wr_ptr[PTR_W-2:0]] <= i_port_a.data;
		end
	end

	// ==========================================================
	// Outputs
	assign o_port_a_data = out_a;
	assign o_port_b_data = out_b;
	assign o_port_a_data_oe = !i_port_a.direction; // RULE_20
	assign o_port_b_data_oe = i_port_b.direction; // RULE_21
	assign o_full_or_input_ready_flag = live && (prog_left != 2'h0 || !q_full); // RULE_02
	assign o_empty_or_output_ready_flag = live && (cfg.fall_through ? hold_valid : (!q_empty || lane != 2'h0)); // RULE_25
	assign o_almost_empty_flag_n = count > {1'b0, cfg.ofs_empty};
	assign o_almost_full_flag_n = (DEPTH_COUNT - count) > {1'b0, cfg.ofs_full};
	assign o_first_mailbox_flag = flag1;
	assign o_second_mailbox_flag = flag2;

	// ==========================================================
	// Assertions
	mbx1_write_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // RULE_12
		a_wr && i_port_a.mailbox_select && flag1 && !mrs_act && !prs_act |=> !o_first_mailbox_flag && mbx1 == $past(i_port_a.data))
		else $error("first mailbox write did not drop its flag");
	mbx1_read_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // RULE_12
		b_rd && i_port_b.mailbox_select && !(a_wr && i_port_a.mailbox_select) && !mrs_act && !prs_act
		|=> o_first_mailbox_flag && out_b == $past(mbx1))
		else $error("first mailbox read did not raise its flag");
	mbx2_write_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // RULE_13
		b_wr && i_port_b.mailbox_select && flag2 && !mrs_act && !secondary_master_reset_act && !prs_act |=> !o_second_mailbox_flag)
		else $error("second mailbox write did not drop its flag");
	mbx2_read_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // RULE_09
		a_rd && i_port_a.mailbox_select && !mrs_act && !prs_act |=> o_port_a_data == $past(mbx2))
		else $error("port A mailbox read returned wrong data");
	reset_flags_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // RULE_14
		mrs_act || prs_act |=> o_first_mailbox_flag && o_second_mailbox_flag && !o_full_or_input_ready_flag)
		else $error("reset left a mailbox flag low");
	partial_keep_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // RULE_17
		prs_act && !mrs_act |=> wr_ptr == '0 && rd_ptr == '0 && out_b == WORD_ZERO && cfg == $past(cfg))
		else $error("partial reset lost configuration or kept pointers");
	b_no_queue_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // RULE_11
		b_wr && !a_wr |=> wr_ptr == $past(wr_ptr) || $past(mrs_act || prs_act))
		else $error("port B write moved the write pointer");
	rewind_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // RULE_18
		rt_evt && !cfg.fall_through && !mrs_act && !prs_act |=> rd_ptr == '0 && lane == 2'h0)
		else $error("retransmit did not rewind the read pointer");
	serial_shift_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // RULE_04
		cfg.method == OFS_SERIAL && ser_cnt != SER_BITS && !i_offset_select_hi_serial_enable && !mrs_act && !prs_act
		|=> cfg.ofs_empty[0] == $past(i_offset_select_lo_serial_data) && ser_cnt == $past(ser_cnt) + 5'h01)
		else $error("serial bit was not shifted in");
	full_flag_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // RULE_02
		q_full && prog_left == 2'h0 |-> !o_full_or_input_ready_flag)
		else $error("write-side flag shows space while full");

endmodule

// *** bench/dcf_port_b_master.sv ***
`timescale 1ns/1ns
// ==========================================================
// Port B bus master: one request per go, bus garbage when idle
module dcf_port_b_master
	import dcf_pkg::*;
(
	// Clock
	input wire logic i_clock,
	// Command from the bench
	input wire logic i_go,
	input wire logic [1:0] i_kind,
	input wire logic [WORD_W-1:0] i_data,
	// Port B request
	output dcf_port_req_t o_req
);
	logic go_seen;
	initial begin
		o_req = '0;
		o_req.direction = 1'b1;
	end
	always @(posedge i_clock) begin
		// Go is taken at the edge so the bench may drop it right after; kind and data are read 1 ns later
		go_seen = i_go;
		#1;
		if (go_seen) begin
			o_req.enable = 1'b1;
			o_req.direction = (i_kind != 2'h2);
			o_req.mailbox_select = (i_kind != 2'h0);
			o_req.data = i_data;
		end else begin
			o_req.enable = 1'b0;
			o_req.direction = 1'b1;
			// Idle data toggles so a stale value is never mistaken for mail
			o_req.data = ~o_req.data;
		end
	end
endmodule

// *** bench/test_dcf_fifo.sv ***
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_dcf_fifo
	import dcf_pkg::*;
;
	typedef struct {int op; logic [35:0] d; logic [35:0] e; logic f1; logic f2;} dcf_row_t;
	logic clock, arst_n, mrs_n, secondary_master_reset_n, prs_n, rt_n, endian, bm, size, serial_program_select, fs_hi, fs_lo, b_go;
	logic a_oe, b_oe, ready, empty, ae_n, af_n, f1, f2;
	logic [1:0] b_kind;
	logic [19:0] ser;
	logic [35:0] b_wdata, w, a_data, b_data;
	dcf_port_req_t pa, pb;
	int mismatches, checks, cycles, i, k;
	dcf_row_t rows [9];

	dcf_fifo dcf_fifo_inst (.i_clock(clock), .i_arst_n(arst_n), .i_port_a(pa), .i_port_b(pb),
		.i_primary_master_reset_n(mrs_n), .i_secondary_master_reset_n(secondary_master_reset_n), .i_partial_reset_n(prs_n),
		.i_retransmit_strobe_n(rt_n), .i_endian_or_timing_select(endian), .i_bus_match_select(bm),
		.i_size_select(size), .i_serial_program_select(serial_program_select), .i_offset_select_hi_serial_enable(fs_hi),
		.i_offset_select_lo_serial_data(fs_lo), .o_port_a_data(a_data), .o_port_a_data_oe(a_oe),
		.o_port_b_data(b_data), .o_port_b_data_oe(b_oe), .o_full_or_input_ready_flag(ready),
		.o_empty_or_output_ready_flag(empty), .o_almost_empty_flag_n(ae_n), .o_almost_full_flag_n(af_n),
		.o_first_mailbox_flag(f1), .o_second_mailbox_flag(f2));
	dcf_port_b_master dcf_port_b_master_inst (.i_clock(clock), .i_go(b_go), .i_kind(b_kind),
		.i_data(b_wdata), .o_req(pb));

	// ==========================================================
	// Tasks
	task print_verdict;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) begin
			@(posedge clock);
			#1;
		end
	endtask
	task a_op(input logic dir, input logic mbx, input logic [35:0] d);
		pa = '{1'b1, dir, mbx, d};
		cyc(1);
		pa.enable = 1'b0;
		pa.data = ~d;
		cyc(2);
		`CHK("a_oe", !dir, a_oe)
	endtask
	task b_op(input logic [1:0] kd, input logic [35:0] d);
		b_kind = kd;
		b_wdata = d;
		b_go = 1'b1;
		cyc(1);
		b_go = 1'b0;
		#4;
		`CHK("b_oe", kd != 2'h2, b_oe)
		cyc(3);
	endtask
	task mreset(input logic m, input logic s, input logic e, input logic p, input logic h, input logic l);
		bm = m;
		size = s;
		endian = e;
		serial_program_select = p;
		fs_hi = h;
		fs_lo = l;
		mrs_n = 1'b0;
		cyc(6);
		mrs_n = 1'b1;
	endtask
	task wait_ready;
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 40) begin
			cyc(1);
			n++;
		end
		`CHK("ready", 1'b1, ready)
	endtask

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 8000) begin
			mismatches++;
			print_verdict();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		{arst_n, mrs_n, secondary_master_reset_n, prs_n, rt_n, endian, bm, size, serial_program_select, fs_hi, fs_lo, b_go} = 12'h3E4;
		b_kind = 2'h0;
		b_wdata = 36'h0;
		pa = '0;
		rows = '{'{0, 36'h9_8765_4321, 36'h0, 1, 1}, '{0, 36'h0_0000_000F, 36'h0, 1, 1},
			'{1, 36'hA_5A5A_5A5A, 36'h0, 0, 1}, '{1, 36'h0_0000_0001, 36'h0, 0, 1},
			'{4, 36'h0, 36'hA_5A5A_5A5A, 1, 1}, '{5, 36'h3_C3C3_C3C3, 36'h0, 1, 0},
			'{2, 36'h0, 36'h3_C3C3_C3C3, 1, 1}, '{3, 36'h0, 36'h9_8765_4321, 1, 1},
			'{3, 36'h0, 36'h0_0000_000F, 1, 1}};
		repeat (5) @(posedge clock);
		#1;
		arst_n = 1'b1;
		mreset(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
		wait_ready();
		for (i = 0; i < 9; i++) begin
			case (rows[i].op)
				0, 1: a_op(1'b1, rows[i].op == 1, rows[i].d);
				2: a_op(1'b0, 1'b1, rows[i].d);
				default: b_op(2'(rows[i].op - 3), rows[i].d);
			endcase
			if (rows[i].op == 2) `CHK("a_data", rows[i].e, a_data)
			if (rows[i].op == 3 || rows[i].op == 4) `CHK("b_data", rows[i].e, b_data)
			`CHK("flag1", rows[i].f1, f1)
			`CHK("flag2", rows[i].f2, f2)
		end
		`CHK("empty", 1'b0, empty)
		rt_n = 1'b0;
		cyc(4);
		rt_n = 1'b1;
		cyc(6);
		b_op(2'h0, 36'h0);
		`CHK("replay", 36'h9_8765_4321, b_data)
		b_op(2'h2, 36'h0_0000_0077);
		secondary_master_reset_n = 1'b0;
		cyc(6);
		secondary_master_reset_n = 1'b1;
		cyc(6);
		`CHK("flag2", 1'b1, f2)
		a_op(1'b0, 1'b1, 36'h0);
		`CHK("second_mailbox", 36'h0, a_data)
		a_op(1'b1, 1'b1, 36'h0_0000_0005);
		prs_n = 1'b0;
		cyc(6);
		prs_n = 1'b1;
		cyc(4);
		`CHK("flag1", 1'b1, f1)
		`CHK("empty", 1'b0, empty)
		`CHK("b_data", 36'h0, b_data)
		wait_ready();
		pa = '{1'b1, 1'b1, 1'b0, 36'h0};
		for (i = 0; i < 1024; i++) begin
			pa.data = 36'(i + 1);
			cyc(1);
			if (i == 1014) `CHK("af_n", 1'b1, af_n)
		end
		pa.enable = 1'b0;
		cyc(3);
		`CHK("full", 1'b0, ready)
		`CHK("af_n", 1'b0, af_n)
		a_op(1'b1, 1'b0, 36'hF_FFFF_FFFF);
		b_op(2'h0, 36'h0);
		`CHK("first", 36'h0_0000_0001, b_data)

		// Byte port, big endian, serial offsets: full 1020, empty 2
		mreset(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
		cyc(8);
		`CHK("b_data", 36'h0, b_data)
		ser = {10'h3FC, 10'h002};
		for (k = 19; k >= 0; k--) begin
			fs_hi = 1'b0;
			fs_lo = ser[k];
			cyc(1);
		end
		fs_hi = 1'b1;
		wait_ready();
		w = 36'h1_2345_6789;
		a_op(1'b1, 1'b0, w);
		a_op(1'b1, 1'b0, ~w);
		cyc(4);
		`CHK("ae_n", 1'b0, ae_n)
		a_op(1'b1, 1'b0, w);
		cyc(4);
		`CHK("ae_n", 1'b1, ae_n)
		`CHK("af_n", 1'b1, af_n)
		a_op(1'b1, 1'b0, w);
		cyc(4);
		`CHK("af_n", 1'b0, af_n)
		for (k = 0; k < 4; k++) begin
			b_op(2'h0, 36'h0);
			`CHK("byte", {27'h0, w[35 - 9 * k -: 9]}, b_data)
		end

		// Long-word port, timing pin low after release picks fall-through
		mreset(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
		endian = 1'b0;
		wait_ready();
		`CHK("empty", 1'b0, empty)
		a_op(1'b1, 1'b0, w);
		cyc(6);
		`CHK("out_ready", 1'b1, empty)
		`CHK("head", w, b_data)
		`CHK("in_ready", 1'b1, ready)
		print_verdict();
	end
endmodule
